/* File: core/aoc_pkg.sv */
// Constants for the output configuration register bank
package aoc_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [12:0] ADDR_FORMAT_CTRL = 13'h0014;
  localparam logic [12:0] ADDR_DRIVE_ADJ   = 13'h0015;
  localparam logic [12:0] ADDR_CLK_PHASE   = 13'h0016;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_FORMAT_CTRL = 8'h00;
  localparam logic [7:0] RST_DRIVE_ADJ   = 8'h00;
  localparam logic [7:0] RST_CLK_PHASE   = 8'h03;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int FMT_LSB       = 0;
  localparam int FMT_MSB       = 1;
  localparam int INVERT_BIT    = 2;
  localparam int LOWPWR_BIT    = 6;
  localparam int DRIVE2X_BIT   = 0;
  localparam int TERM_LSB      = 4;
  localparam int TERM_MSB      = 5;
  localparam int PHASE_LSB     = 0;
  localparam int PHASE_MSB     = 3;

  // ---------------------------------------------------------------
  // Data format codes
  // ---------------------------------------------------------------
  localparam logic [1:0] FMT_OFFSET_BIN = 2'h0;
  localparam logic [1:0] FMT_TWOS_COMP  = 2'h1;

  // ---------------------------------------------------------------
  // Phase codes and offsets in degrees
  // ---------------------------------------------------------------
  localparam logic [3:0] PH_CODE_0   = 4'h0;
  localparam logic [3:0] PH_CODE_60  = 4'h1;
  localparam logic [3:0] PH_CODE_120 = 4'h2;
  localparam logic [3:0] PH_CODE_180 = 4'h3;
  localparam logic [3:0] PH_CODE_300 = 4'h5;
  localparam logic [3:0] PH_CODE_360 = 4'h6;
  localparam logic [3:0] PH_CODE_480 = 4'h8;
  localparam logic [3:0] PH_CODE_540 = 4'h9;
  localparam logic [9:0] DEG_0   = 10'h000;
  localparam logic [9:0] DEG_60  = 10'h03c;
  localparam logic [9:0] DEG_120 = 10'h078;
  localparam logic [9:0] DEG_180 = 10'h0b4;
  localparam logic [9:0] DEG_300 = 10'h12c;
  localparam logic [9:0] DEG_360 = 10'h168;
  localparam logic [9:0] DEG_480 = 10'h1e0;
  localparam logic [9:0] DEG_540 = 10'h21c;

  // ---------------------------------------------------------------
  // Serial port framing
  // ---------------------------------------------------------------
  localparam logic [4:0] SPI_INSTR_LAST = 5'h0f;
  localparam logic [4:0] SPI_DATA_LAST  = 5'h17;
  localparam int         SPI_RW_BIT     = 15;

endpackage

/* File: core/aoc_spi.sv */
// Serial port engine: instruction, address and one data byte
`timescale 1ns/10ps
module aoc_spi (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_sclk,
  input  wire logic        i_csb_n,
  input  wire logic        i_sdio,
  input  wire logic [7:0]  i_rdata,
  output logic             o_sdio,
  output logic             o_sdio_oe,
  output logic             o_wr,
  output logic             o_rd,
  output logic [12:0]      o_addr,
  output logic [7:0]       o_wdata
);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [2:0]  sclk_q;
  logic [1:0]  csb_q;
  logic [1:0]  sdio_q;
  logic        rise;
  logic        fall;
  logic        sel;
  logic [4:0]  cnt_q;
  logic [15:0] instr_q;
  logic [7:0]  din_q;
  logic [7:0]  dout_q;
  logic        load_q;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sclk_q <= 3'h0;
      csb_q  <= 2'h3;
      sdio_q <= 2'h0;
    end else begin
      sclk_q <= {sclk_q[1:0], i_sclk};
      csb_q  <= {csb_q[0], i_csb_n};
      sdio_q <= {sdio_q[0], i_sdio};
    end
  end

  assign rise = sclk_q[1] & ~sclk_q[2];
  assign fall = ~sclk_q[1] & sclk_q[2];
  assign sel  = ~csb_q[1];

  // ---------------------------------------------------------------
  // Shift in on rising edges
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst || !sel) begin
      cnt_q   <= 5'h00;
      instr_q <= 16'h0000;
      din_q   <= 8'h00;
    end else if (rise && cnt_q <= aoc_pkg::SPI_DATA_LAST) begin
      cnt_q <= cnt_q + 5'h01;
      if (cnt_q <= aoc_pkg::SPI_INSTR_LAST) begin
        instr_q <= {instr_q[14:0], sdio_q[1]};
      end else begin
        din_q <= {din_q[6:0], sdio_q[1]};
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_wr    <= 1'b0;
      o_rd    <= 1'b0;
      o_addr  <= 13'h0000;
      o_wdata <= 8'h00;
    end else begin
      o_rd <= sel && rise && cnt_q == aoc_pkg::SPI_INSTR_LAST
              && instr_q[aoc_pkg::SPI_RW_BIT - 1];
      o_wr <= sel && rise && cnt_q == aoc_pkg::SPI_DATA_LAST
              && !instr_q[aoc_pkg::SPI_RW_BIT];
      if (sel && rise && cnt_q == aoc_pkg::SPI_INSTR_LAST) begin
        o_addr <= {instr_q[11:0], sdio_q[1]};
      end
      if (sel && rise && cnt_q == aoc_pkg::SPI_DATA_LAST) begin
        o_wdata <= {din_q[6:0], sdio_q[1]};
      end
    end
  end

  // ---------------------------------------------------------------
  // Read data out on falling edges
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      load_q <= 1'b0;
    end else begin
      load_q <= o_rd;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst || !sel) begin
      dout_q    <= 8'h00;
      o_sdio    <= 1'b0;
      o_sdio_oe <= 1'b0;
    end else if (load_q) begin
      dout_q    <= i_rdata;
      o_sdio_oe <= 1'b1;
    end else if (fall && o_sdio_oe) begin
      o_sdio <= dout_q[7];
      dout_q <= {dout_q[6:0], 1'b0};
    end
  end

endmodule // aoc_spi

/* File: core/aoc_top.sv */
// Output format, drive and clock phase configuration registers
// Function
// - Format 00 offset binary, 01 twos complement
// - Invert bit per channel; others shared
// - Bit0 doubles clock drive, per channel
// - Phase codes 0-3 give 0-180 degrees
// - Codes 1000, 1001 give 480, 540 degrees
// - Phase field selects divider output phase
// - Phase global; internal latching left untouched
// - Phase register resets to 0x03
`timescale 1ns/10ps
module aoc_top #(
  parameter int NCH = 8
) (
  input  wire logic            I_CLOCK,
  input  wire logic            I_RST,
  input  wire logic            I_SCLK,
  input  wire logic            I_CSB_N,
  input  wire logic            I_SDIO,
  input  wire logic [NCH-1:0]  I_CHAN_SEL,
  output logic                 O_SDIO,
  output logic                 O_SDIO_OE,
  output logic                 O_TWOS_COMP,
  output logic [1:0]           O_FORMAT,
  output logic [NCH-1:0]       O_INVERT,
  output logic                 O_LVDS_LOWPWR,
  output logic [1:0]           O_TERM,
  output logic [NCH-1:0]       O_CLK_DRIVE2X,
  output logic [3:0]           O_DIV_PHASE_SEL,
  output logic [9:0]           O_PHASE_DEG
);

  // ---------------------------------------------------------------
  // Serial port
  // ---------------------------------------------------------------
  logic        wr;
  logic        rd;
  logic [12:0] addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;

  aoc_spi u_spi (
    .i_clk     (I_CLOCK),
    .i_rst     (I_RST),
    .i_sclk    (I_SCLK),
    .i_csb_n   (I_CSB_N),
    .i_sdio    (I_SDIO),
    .i_rdata   (rdata),
    .o_sdio    (O_SDIO),
    .o_sdio_oe (O_SDIO_OE),
    .o_wr      (wr),
    .o_rd      (rd),
    .o_addr    (addr),
    .o_wdata   (wdata)
  );

  // ---------------------------------------------------------------
  // Register storage
  // ---------------------------------------------------------------
  logic [7:0]     fmt_glb_q;
  logic [NCH-1:0] invert_q;
  logic [7:0]     drv_glb_q;
  logic [NCH-1:0] drive2x_q;
  logic [7:0]     phase_q;
  logic [9:0]     deg_d;
  logic           deg_ok;
  logic           first_inv;
  logic           first_drv;

  // Shared bits of the format register
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      fmt_glb_q <= aoc_pkg::RST_FORMAT_CTRL;
    end else if (wr && addr == aoc_pkg::ADDR_FORMAT_CTRL) begin
      fmt_glb_q <= wdata;
    end
  end

  // Per-channel invert bits
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      invert_q <= {NCH{aoc_pkg::RST_FORMAT_CTRL[aoc_pkg::INVERT_BIT]}};
    end else if (wr && addr == aoc_pkg::ADDR_FORMAT_CTRL) begin
      for (int i = 0; i < NCH; i++) begin
        if (I_CHAN_SEL[i]) begin
          invert_q[i] <= wdata[aoc_pkg::INVERT_BIT];
        end
      end
    end
  end

  // Shared bits of the drive register
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      drv_glb_q <= aoc_pkg::RST_DRIVE_ADJ;
    end else if (wr && addr == aoc_pkg::ADDR_DRIVE_ADJ) begin
      drv_glb_q <= wdata;
    end
  end

  // Per-channel clock drive doubling
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      drive2x_q <= {NCH{aoc_pkg::RST_DRIVE_ADJ[aoc_pkg::DRIVE2X_BIT]}};
    end else if (wr && addr == aoc_pkg::ADDR_DRIVE_ADJ) begin
      for (int i = 0; i < NCH; i++) begin
        if (I_CHAN_SEL[i]) begin
          drive2x_q[i] <= wdata[aoc_pkg::DRIVE2X_BIT];
        end
      end
    end
  end

  // Global phase register
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      phase_q <= aoc_pkg::RST_CLK_PHASE;
    end else if (wr && addr == aoc_pkg::ADDR_CLK_PHASE) begin
      phase_q <= wdata;
    end
  end

  // ---------------------------------------------------------------
  // Phase decode
  // ---------------------------------------------------------------
  always_comb begin
    deg_ok = 1'b1;
    unique case (phase_q[aoc_pkg::PHASE_MSB:aoc_pkg::PHASE_LSB])
      aoc_pkg::PH_CODE_0:   deg_d = aoc_pkg::DEG_0;
      aoc_pkg::PH_CODE_60:  deg_d = aoc_pkg::DEG_60;
      aoc_pkg::PH_CODE_120: deg_d = aoc_pkg::DEG_120;
      aoc_pkg::PH_CODE_180: deg_d = aoc_pkg::DEG_180;
      aoc_pkg::PH_CODE_300: deg_d = aoc_pkg::DEG_300;
      aoc_pkg::PH_CODE_360: deg_d = aoc_pkg::DEG_360;
      aoc_pkg::PH_CODE_480: deg_d = aoc_pkg::DEG_480;
      aoc_pkg::PH_CODE_540: deg_d = aoc_pkg::DEG_540;
      default: begin
        // Reserved code: keep last valid offset
        deg_d  = O_PHASE_DEG;
        deg_ok = 1'b0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      O_FORMAT      <= aoc_pkg::FMT_OFFSET_BIN;
      O_TWOS_COMP   <= 1'b0;
      O_INVERT      <= '0;
      O_LVDS_LOWPWR <= 1'b0;
      O_TERM        <= 2'h0;
      O_CLK_DRIVE2X <= '0;
    end else begin
      O_FORMAT      <= fmt_glb_q[aoc_pkg::FMT_MSB:aoc_pkg::FMT_LSB];
      O_TWOS_COMP   <= fmt_glb_q[aoc_pkg::FMT_MSB:aoc_pkg::FMT_LSB]
                       == aoc_pkg::FMT_TWOS_COMP;
      O_INVERT      <= invert_q;
      O_LVDS_LOWPWR <= fmt_glb_q[aoc_pkg::LOWPWR_BIT];
      O_TERM        <= drv_glb_q[aoc_pkg::TERM_MSB:aoc_pkg::TERM_LSB];
      O_CLK_DRIVE2X <= drive2x_q;
    end
  end

  // Divider tap feeds only the clock output path
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      O_DIV_PHASE_SEL <= aoc_pkg::RST_CLK_PHASE[3:0];
      O_PHASE_DEG     <= aoc_pkg::DEG_180;
    end else begin
      O_DIV_PHASE_SEL <= phase_q[aoc_pkg::PHASE_MSB:aoc_pkg::PHASE_LSB];
      if (deg_ok) begin
        O_PHASE_DEG <= deg_d;
      end
    end
  end

  // ---------------------------------------------------------------
  // Read back
  // ---------------------------------------------------------------
  // Local bits read from lowest selected channel
  always_comb begin
    first_inv = 1'b0;
    first_drv = 1'b0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (I_CHAN_SEL[i]) begin
        first_inv = invert_q[i];
        first_drv = drive2x_q[i];
      end
    end
  end

  always_comb begin
    rdata = 8'h00;
    if (addr == aoc_pkg::ADDR_FORMAT_CTRL) begin
      rdata = fmt_glb_q;
      rdata[aoc_pkg::INVERT_BIT] = first_inv;
    end else if (addr == aoc_pkg::ADDR_DRIVE_ADJ) begin
      rdata = drv_glb_q;
      rdata[aoc_pkg::DRIVE2X_BIT] = first_drv;
    end else if (addr == aoc_pkg::ADDR_CLK_PHASE) begin
      rdata = phase_q;
    end
  end

  logic unused_rd;
  assign unused_rd = rd;

endmodule // aoc_top

/* File: bench/aoc_properties.sv */
// Concurrent checks on the configuration register bank ports
`timescale 1ns/10ps
module aoc_properties #(
  parameter int NCH = 8
) (
  input wire logic           I_CLOCK,
  input wire logic           I_RST,
  input wire logic           I_SCLK,
  input wire logic           I_CSB_N,
  input wire logic [NCH-1:0] I_CHAN_SEL,
  input wire logic           O_SDIO,
  input wire logic           O_SDIO_OE,
  input wire logic           O_TWOS_COMP,
  input wire logic [1:0]     O_FORMAT,
  input wire logic [NCH-1:0] O_INVERT,
  input wire logic           O_LVDS_LOWPWR,
  input wire logic [1:0]     O_TERM,
  input wire logic [NCH-1:0] O_CLK_DRIVE2X,
  input wire logic [3:0]     O_DIV_PHASE_SEL,
  input wire logic [9:0]     O_PHASE_DEG
);
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (I_RST);

  function automatic logic [9:0] deg_of(input logic [3:0] c);
    case (c)
      4'h1:    deg_of = 10'h03c;
      4'h2:    deg_of = 10'h078;
      4'h3:    deg_of = 10'h0b4;
      4'h5:    deg_of = 10'h12c;
      4'h6:    deg_of = 10'h168;
      4'h8:    deg_of = 10'h1e0;
      4'h9:    deg_of = 10'h21c;
      default: deg_of = 10'h000;
    endcase
  endfunction

  a_twos_from_fmt:
    assert property (O_TWOS_COMP == (O_FORMAT == 2'h1)) else $error("Format flag mismatch");
  a_reset_phase:
    assert property (disable iff (1'b0) I_RST ##1 I_RST |=>
      O_DIV_PHASE_SEL == 4'h3 && O_PHASE_DEG == 10'h0b4) else $error("Phase reset wrong");
  a_reset_config:
    assert property (disable iff (1'b0) I_RST ##1 I_RST |=> O_FORMAT == 2'h0 &&
      O_INVERT == '0 && O_CLK_DRIVE2X == '0 && O_TERM == 2'h0 && !O_LVDS_LOWPWR)
      else $error("Config reset wrong");
  a_phase_decode:
    assert property ($changed(O_DIV_PHASE_SEL) &&
      O_DIV_PHASE_SEL inside {4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h8, 4'h9}
      |=> O_PHASE_DEG == deg_of($past(O_DIV_PHASE_SEL))) else $error("Phase decode wrong");
  a_deg_follows_sel:
    assert property ($changed(O_PHASE_DEG) |->
      $changed(O_DIV_PHASE_SEL)) else $error("Degrees moved alone");
  a_idle_config_held:
    assert property (I_CSB_N [*8] |=> $stable({O_FORMAT, O_INVERT, O_LVDS_LOWPWR, O_TERM,
      O_CLK_DRIVE2X, O_DIV_PHASE_SEL})) else $error("Config changed while idle");
  a_local_bits_sel:
    assert property ((({O_INVERT, O_CLK_DRIVE2X} ^ $past({O_INVERT, O_CLK_DRIVE2X}))
      & ~{I_CHAN_SEL, I_CHAN_SEL}) == '0) else $error("Unselected channel changed");
  a_oe_idle_low:
    assert property (I_CSB_N [*4] |-> !O_SDIO_OE) else $error("Read driver left on");
  a_sdio_on_low:
    assert property ($changed(O_SDIO) |-> !I_SCLK) else $error("Read data moved on high");
endmodule // aoc_properties

/* File: bench/test_adc_output_config_regs.sv */
// Self-checking testbench for the configuration register bank
`timescale 1ns/10ps
module test_adc_output_config_regs;
  localparam int H = 8;
  logic       I_CLOCK, I_RST, I_SCLK, I_CSB_N, I_SDIO;
  logic [7:0] I_CHAN_SEL, O_INVERT, O_CLK_DRIVE2X, rdv;
  logic       O_SDIO, O_SDIO_OE, O_TWOS_COMP, O_LVDS_LOWPWR;
  logic       oev;
  logic [1:0] O_FORMAT, O_TERM;
  logic [3:0] O_DIV_PHASE_SEL;
  logic [9:0] O_PHASE_DEG;
  int         num_errors  = 0;
  int         checks_done = 0;
  logic [3:0] codes [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h8, 4'h9};
  logic [9:0] degs [8]  = '{10'h000, 10'h03c, 10'h078, 10'h0b4, 10'h12c, 10'h168,
                            10'h1e0, 10'h21c};

  aoc_top #(.NCH(8)) uut (.I_CLOCK, .I_RST, .I_SCLK, .I_CSB_N, .I_SDIO, .I_CHAN_SEL,
    .O_SDIO, .O_SDIO_OE, .O_TWOS_COMP, .O_FORMAT, .O_INVERT, .O_LVDS_LOWPWR, .O_TERM,
    .O_CLK_DRIVE2X, .O_DIV_PHASE_SEL, .O_PHASE_DEG);

  initial begin
    I_CLOCK = 1'b0;
    forever #50 I_CLOCK = ~I_CLOCK;
  end

  // ---------------------------------------------------------------
  // Serial access tasks
  // ---------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge I_CLOCK);
    #1;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Slow serial clock, read bits taken just before each rise
  task automatic frame(input logic [15:0] ins, input logic [7:0] wd);
    logic [23:0] sh;
    sh = {ins, wd};
    I_CSB_N = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      I_SDIO = sh[i];
      tick(H);
      if (i < 8) rdv[i] = O_SDIO;
      if (i == 0) oev = O_SDIO_OE;
      I_SCLK = 1'b1;
      tick(H);
      I_SCLK = 1'b0;
    end
    tick(H);
    I_CSB_N = 1'b1;
    tick(10);
  endtask

  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    frame({3'h0, a}, d);
    chk(16'(oev), 16'h0000);
  endtask

  task automatic rd(input logic [12:0] a, input logic [7:0] exp);
    frame({3'h4, a}, 8'h00);
    chk(16'(rdv), 16'(exp));
    chk(16'(oev), 16'h0001);
  endtask

  task automatic give_verdict;
    $display("Checks: %0d errors: %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------
  initial begin
    I_RST = 1'b1;
    I_SCLK = 1'b0;
    I_CSB_N = 1'b1;
    I_SDIO = 1'b0;
    I_CHAN_SEL = 8'h05;
    tick(5);
    I_RST = 1'b0;
    tick(3);
    chk(16'(O_DIV_PHASE_SEL), 16'h0003);
    chk(16'(O_PHASE_DEG), 16'h00b4);
    rd(13'h0016, 8'h03);
    rd(13'h0014, 8'h00);
    rd(13'h0015, 8'h00);
    rd(13'h0017, 8'h00);
    wr(13'h0014, 8'h45);
    chk(16'(O_TWOS_COMP), 16'h0001);
    chk(16'(O_FORMAT), 16'h0001);
    chk(16'(O_INVERT), 16'h0005);
    chk(16'(O_LVDS_LOWPWR), 16'h0001);
    I_CHAN_SEL = 8'h02;
    wr(13'h0014, 8'h00);
    chk(16'(O_INVERT), 16'h0005);
    chk(16'(O_LVDS_LOWPWR), 16'h0000);
    chk(16'(O_TWOS_COMP), 16'h0000);
    I_CHAN_SEL = 8'h80;
    wr(13'h0015, 8'h31);
    chk(16'(O_CLK_DRIVE2X), 16'h0080);
    chk(16'(O_TERM), 16'h0003);
    rd(13'h0015, 8'h31);
    I_CHAN_SEL = 8'h00;
    for (int k = 0; k < 8; k++) begin
      wr(13'h0016, {4'h0, codes[k]});
      chk(16'(O_DIV_PHASE_SEL), 16'(codes[k]));
      chk(16'(O_PHASE_DEG), 16'(degs[k]));
    end
    rd(13'h0016, 8'h09);
    chk(16'(O_CLK_DRIVE2X), 16'h0080);
    I_RST = 1'b1;
    tick(3);
    I_RST = 1'b0;
    tick(3);
    chk(16'(O_PHASE_DEG), 16'h00b4);
    chk(16'(O_CLK_DRIVE2X), 16'h0000);
    give_verdict();
  end

  initial begin
    #2000000;
    num_errors++;
    give_verdict();
  end
endmodule // test_adc_output_config_regs

bind aoc_top aoc_properties #(.NCH(NCH)) u_props (.I_CLOCK, .I_RST, .I_SCLK, .I_CSB_N,
  .I_CHAN_SEL, .O_SDIO, .O_SDIO_OE, .O_TWOS_COMP, .O_FORMAT, .O_INVERT, .O_LVDS_LOWPWR,
  .O_TERM, .O_CLK_DRIVE2X, .O_DIV_PHASE_SEL, .O_PHASE_DEG);
